// ==== oef_event_flags.sv ====
// OTG event flags, enable mask and interrupt gating behind a command-code port.
//
// Summary of operation
// - Session-end level change in either direction sets flag bit 2.
// - Bus-voltage-valid level toggle sets flag bit 1.
// - Plug ID level change sets flag bit 0.
// - Writing one clears a flag; writing zero leaves it.
// - Enable mask is read with code 69h and written with code E9h.
// - Enable bit 10 gates the timer expiry interrupt.
// - Enable bit 9 gates the long single-ended-zero interrupt.
// - Enable bit 8 gates the session request interrupt.
// - Enable bit 7 gates the resume interrupt; only J to K counts.
// - Enable bit 6 gates the bus suspend interrupt.
// - Enable bit 5 gates the remote connection change interrupt.
// - Enable bit 4 gates the B session valid change interrupt.
// - Enable bit 3 gates the A session valid change interrupt.
// - Enable bit 2 gates the session-end change interrupt.
// - Enable bit 1 gates the bus-voltage-valid change interrupt.
// - Enable bit 0 gates the ID change interrupt; all resets zero, 15-11 reserved.
// - Single-ended zero held over 2 ms sets the long SE0 flag.
// - Bus idle over 3 ms sets the suspend flag.
// - J to K change while suspended sets the resume flag.
// - Session request from bus-voltage or data-line pulsing, chosen by control bit.
`timescale 1ns/100ps
`include "oef_regs.svh"

module oef_event_flags #(
	parameter int unsigned SE0_CYCLES  = `OEF_SE0_CYCLES,
	parameter int unsigned IDLE_CYCLES = `OEF_IDLE_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire oef_pkg::oef_cmd_t regAddr,
	input  wire oef_pkg::oef_word_t regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output oef_pkg::oef_word_t     regRdata,
	input  wire logic              sessionEndLevel,
	input  wire logic              busVoltageValidLevel,
	input  wire logic              plugIdLevel,
	input  wire logic              lineSe0,
	input  wire logic              lineJ,
	input  wire logic              lineK,
	input  wire logic              timerExpiredPulse,
	input  wire logic              remoteConnChangePulse,
	input  wire logic              bSessionValidChangePulse,
	input  wire logic              aSessionValidChangePulse,
	input  wire logic              vbusPulsingSeen,
	input  wire logic              dataLinePulsingSeen,
	output logic                   otgIrq
);

	import oef_pkg::*;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// True when a strobe carries the given command code.
	function automatic logic cmdHit(input logic strobe, input oef_cmd_t addr,
		input oef_cmd_t code);
		return strobe && (addr == code);
	endfunction

	// Widens an event vector into a bus word with the reserved bits at zero.
	function automatic oef_word_t toWord(input oef_evt_t v);
		return {5'h00, v};
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------

	localparam int LV_SESS = 0;
	localparam int LV_VBUS = 1;
	localparam int LV_ID   = 2;
	localparam int LV_SE0  = 3;
	localparam int LV_J    = 4;
	localparam int LV_K    = 5;

	logic [5:0] meta_q;
	logic [5:0] sync_q;
	logic [5:0] prev_q;
	logic [2:0] settle_q;
	logic       armed;

	// Two flip-flops on every pin level before any logic reads it.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta_q <= 6'h00;
			sync_q <= 6'h00;
		end
		else
		begin
			meta_q <= {lineK, lineJ, lineSe0, plugIdLevel, busVoltageValidLevel,
				sessionEndLevel};
			sync_q <= meta_q;
		end
	end

	// Keeps the previous synchronised levels for change detection.
	always_ff @(posedge clk)
	begin
		if (srst)
			prev_q <= 6'h00;
		else
			prev_q <= sync_q;
	end

	// Holds off change detection until the synchronisers carry real pin levels.
	always_ff @(posedge clk)
	begin
		if (srst)
			settle_q <= 3'h0;
		else
			settle_q <= {settle_q[1:0], 1'b1};
	end

	assign armed = settle_q[2];

	// ------------------------------------------------------------------------
	// Bus timing detectors
	// ------------------------------------------------------------------------

	logic se0Expired;
	logic idleExpired;
	logic lineIdle;

	// The idle bus rests in J; any single-ended zero breaks the idle time.
	assign lineIdle = sync_q[LV_J] && !sync_q[LV_SE0];

	// Long single-ended zero detector.
	oef_duration_timer #(
		.LIMIT (SE0_CYCLES)
	) se0Timer (
		.clk     (clk),
		.srst    (srst),
		.level   (sync_q[LV_SE0]),
		.expired (se0Expired)
	);

	// Idle bus detector for suspend.
	oef_duration_timer #(
		.LIMIT (IDLE_CYCLES)
	) idleTimer (
		.clk     (clk),
		.srst    (srst),
		.level   (lineIdle),
		.expired (idleExpired)
	);

	// ------------------------------------------------------------------------
	// Suspend tracking
	// ------------------------------------------------------------------------

	oef_line_st_t lineSt_q;
	logic         jToK;

	// A resume needs the bus to step straight from J to K.
	assign jToK = prev_q[LV_J] && sync_q[LV_K];

	// Enters suspend after the idle time and leaves it on any non-idle state.
	always_ff @(posedge clk)
	begin
		if (srst)
			lineSt_q <= OEF_LINE_ACTIVE;
		else
		begin
			case (lineSt_q)
				OEF_LINE_ACTIVE:
					if (idleExpired)
						lineSt_q <= OEF_LINE_SUSPENDED;
				OEF_LINE_SUSPENDED:
					if (!lineIdle)
						lineSt_q <= OEF_LINE_ACTIVE;
				default:
					lineSt_q <= OEF_LINE_ACTIVE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------------

	logic srpSelect_q;
	logic srpEvent;

	// Chooses data-line pulsing when set, bus-voltage pulsing when clear.
	always_ff @(posedge clk)
	begin
		if (srst)
			srpSelect_q <= `OEF_CTRL_RST;
		else if (cmdHit(regWr, regAddr, `OEF_CMD_CTRL_WR))
			srpSelect_q <= regWdata[`OEF_BIT_SRP_SELECT];
	end

	// Only the selected form of session request is taken.
	assign srpEvent = srpSelect_q ? dataLinePulsingSeen : vbusPulsingSeen;

	// ------------------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------------------

	oef_evt_t flags_q;
	oef_evt_t flags_d;
	oef_evt_t flagSet;
	oef_evt_t flagClr;

	// Gathers this cycle's events into one vector.
	always_comb
	begin
		flagSet = '0;
		flagSet[`OEF_BIT_SESS_END]   = armed && (sync_q[LV_SESS] != prev_q[LV_SESS]);
		flagSet[`OEF_BIT_VBUS_VLD]   = armed && (sync_q[LV_VBUS] != prev_q[LV_VBUS]);
		flagSet[`OEF_BIT_PLUG_ID]    = armed && (sync_q[LV_ID] != prev_q[LV_ID]);
		flagSet[`OEF_BIT_A_SESSION]   = aSessionValidChangePulse;
		flagSet[`OEF_BIT_B_SESSION]   = bSessionValidChangePulse;
		flagSet[`OEF_BIT_REMOTE_CONN] = remoteConnChangePulse;
		flagSet[`OEF_BIT_SUSPEND]    = idleExpired;
		flagSet[`OEF_BIT_RESUME]     = armed && (lineSt_q == OEF_LINE_SUSPENDED) && jToK;
		flagSet[`OEF_BIT_SRP]        = srpEvent;
		flagSet[`OEF_BIT_LONG_SE0]   = se0Expired;
		flagSet[`OEF_BIT_TIMER]      = timerExpiredPulse;
	end

	// Write-one-to-clear; an event in the clearing cycle still sets the flag.
	always_comb
	begin
		flagClr = '0;
		if (cmdHit(regWr, regAddr, `OEF_CMD_FLAGS_WR))
			flagClr = regWdata[`OEF_EVT_W-1:0];
		flags_d = (flags_q & ~flagClr) | flagSet;
	end

	// Holds the sticky flags.
	always_ff @(posedge clk)
	begin
		if (srst)
			flags_q <= `OEF_FLAGS_RST;
		else
			flags_q <= flags_d;
	end

	// ------------------------------------------------------------------------
	// Enable mask
	// ------------------------------------------------------------------------

	oef_evt_t mask_q;

	// Eleven enable bits; bits 15 to 11 of the write word are dropped.
	always_ff @(posedge clk)
	begin
		if (srst)
			mask_q <= `OEF_MASK_RST;
		else if (cmdHit(regWr, regAddr, `OEF_CMD_MASK_WR))
			mask_q <= regWdata[`OEF_EVT_W-1:0];
	end

	// ------------------------------------------------------------------------
	// Interrupt output
	// ------------------------------------------------------------------------

	logic irq_q;

	// Each enable bit gates its own flag; any surviving flag raises the line.
	always_ff @(posedge clk)
	begin
		if (srst)
			irq_q <= 1'b0;
		else
			irq_q <= |(flags_q & mask_q);
	end

	assign otgIrq = irq_q;

	// ------------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------------

	oef_word_t rdata_q;

	// Read data stand for one cycle after the strobe; unknown codes read zero.
	always_ff @(posedge clk)
	begin
		if (srst || !regRd)
			rdata_q <= `OEF_WORD_ZERO;
		else if (regAddr == `OEF_CMD_MASK_RD)
			rdata_q <= toWord(mask_q);
		else if (regAddr == `OEF_CMD_FLAGS_RD)
			rdata_q <= toWord(flags_q);
		else if (regAddr == `OEF_CMD_CTRL_RD)
			rdata_q <= {15'h0000, srpSelect_q};
		else
			rdata_q <= `OEF_WORD_ZERO;
	end

	assign regRdata = rdata_q;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (srst);

	// A write to the flag register.
	sequence flagWrite;
		regWr && (regAddr == `OEF_CMD_FLAGS_WR);
	endsequence

	// A read of the enable mask.
	sequence maskRead;
		regRd && (regAddr == `OEF_CMD_MASK_RD);
	endsequence

	// Bus steps from J to K while suspended.
	sequence resumeSeen;
		armed && (lineSt_q == OEF_LINE_SUSPENDED) && prev_q[LV_J] && sync_q[LV_K];
	endsequence

	AST_SESS_END_CHANGE: assert property (
		armed && $changed(sync_q[LV_SESS]) |=> flags_q[`OEF_BIT_SESS_END])
		else $error("Session-end change not flagged.");

	AST_VBUS_CHANGE: assert property (
		armed && $changed(sync_q[LV_VBUS]) |=> flags_q[`OEF_BIT_VBUS_VLD])
		else $error("Bus-voltage-valid change not flagged.");

	AST_ID_CHANGE: assert property (
		armed && $changed(sync_q[LV_ID]) |=> flags_q[`OEF_BIT_PLUG_ID])
		else $error("Plug ID change not flagged.");

	AST_W1C_ZERO_KEEPS: assert property (
		flagWrite ##0 (flags_q[0] && !regWdata[0]) |=> flags_q[0])
		else $error("Writing zero cleared a flag.");

	AST_W1C_ONE_CLEARS: assert property (
		flagWrite ##0 (regWdata[1] && !flagSet[1]) |=> !flags_q[1])
		else $error("Writing one did not clear a flag.");

	AST_MASK_READBACK: assert property (
		maskRead |=> regRdata == {5'h00, $past(mask_q)})
		else $error("Mask read returned the wrong word.");

	AST_IRQ_GATING: assert property (
		##1 otgIrq == |($past(flags_q) & $past(mask_q)))
		else $error("Interrupt does not follow flags and enables.");

	AST_MASK_RESET: assert property (
		$past(srst) |-> mask_q == 11'h000)
		else $error("Enable mask not zero after reset.");

	AST_LONG_SE0: assert property (
		se0Expired |=> flags_q[`OEF_BIT_LONG_SE0])
		else $error("Long SE0 not flagged.");

	AST_RESUME: assert property (
		resumeSeen |=> flags_q[`OEF_BIT_RESUME])
		else $error("Resume not flagged.");

	AST_SRP_SELECT: assert property (
		!srpSelect_q && vbusPulsingSeen |=> flags_q[`OEF_BIT_SRP])
		else $error("Selected session request not flagged.");

endmodule // oef_event_flags

// ==== oef_regs.svh ====
// Register codes, bit positions, reset values and timing counts of the OTG event block.
`ifndef OEF_REGS_SVH
`define OEF_REGS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define OEF_CMD_CTRL_RD     8'h67
`define OEF_CMD_FLAGS_RD    8'h68
`define OEF_CMD_MASK_RD     8'h69
`define OEF_CMD_CTRL_WR     8'hE7
`define OEF_CMD_FLAGS_WR    8'hE8
`define OEF_CMD_MASK_WR     8'hE9

// ----------------------------------------------------------------------------
// Event bit positions, shared by the flag and enable registers
// ----------------------------------------------------------------------------
`define OEF_BIT_PLUG_ID     0
`define OEF_BIT_VBUS_VLD    1
`define OEF_BIT_SESS_END    2
`define OEF_BIT_A_SESSION   3
`define OEF_BIT_B_SESSION   4
`define OEF_BIT_REMOTE_CONN 5
`define OEF_BIT_SUSPEND     6
`define OEF_BIT_RESUME      7
`define OEF_BIT_SRP         8
`define OEF_BIT_LONG_SE0    9
`define OEF_BIT_TIMER       10
`define OEF_EVT_W           11
`define OEF_BIT_SRP_SELECT  0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OEF_MASK_RST        11'h000
`define OEF_FLAGS_RST       11'h000
`define OEF_CTRL_RST        1'h0
`define OEF_WORD_ZERO       16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OEF_CLK_PERIOD_NS   10
`define OEF_SE0_TIME_US     2000
`define OEF_IDLE_TIME_US    3000
`define OEF_SE0_CYCLES      ((`OEF_SE0_TIME_US * 1000 + `OEF_CLK_PERIOD_NS - 1) / `OEF_CLK_PERIOD_NS)
`define OEF_IDLE_CYCLES     ((`OEF_IDLE_TIME_US * 1000 + `OEF_CLK_PERIOD_NS - 1) / `OEF_CLK_PERIOD_NS)
`define OEF_DUR_W           20

`endif

// ==== oef_pkg.sv ====
// Types shared by the OTG event block.
package oef_pkg;

	typedef logic [7:0]  oef_cmd_t;
	typedef logic [15:0] oef_word_t;
	typedef logic [10:0] oef_evt_t;

	// Bus line condition used for resume detection.
	typedef enum logic [0:0] {
		OEF_LINE_ACTIVE,
		OEF_LINE_SUSPENDED
	} oef_line_st_t;

endpackage

// ==== oef_duration_timer.sv ====
// Detector that pulses once when a level has been held longer than a set count.
`timescale 1ns/100ps
`include "oef_regs.svh"

module oef_duration_timer #(
	parameter int unsigned LIMIT = 4
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic level,
	output logic      expired
);

	localparam logic [`OEF_DUR_W-1:0] LIM = LIMIT[`OEF_DUR_W-1:0];

	logic [`OEF_DUR_W-1:0] cnt_q;
	logic                  expired_q;

	// Counts cycles of the held level and saturates one past the limit.
	always_ff @(posedge clk)
	begin
		if (srst || !level)
			cnt_q <= '0;
		else if (cnt_q <= LIM)
			cnt_q <= cnt_q + 1'b1;
	end

	// Pulses once when the level stays beyond the limit, so the time is exceeded.
	always_ff @(posedge clk)
	begin
		if (srst)
			expired_q <= 1'b0;
		else
			expired_q <= level && (cnt_q == LIM);
	end

	assign expired = expired_q;

	AST_DUR_ONLY_AFTER_LIMIT: assert property (
		@(posedge clk) disable iff (srst) expired_q |-> $past(cnt_q) == LIM)
		else $error("Duration pulse without a full count.");

endmodule // oef_duration_timer

// ==== tb_oef_event_flags.sv ====
// Self-checking testbench of the OTG event flag and enable block.
`timescale 1ns/100ps
`include "oef_regs.svh"

module tb_oef_event_flags;
	import oef_pkg::*;

	localparam int unsigned SE0_N  = 20;
	localparam int unsigned IDLE_N = 30;
	localparam oef_cmd_t    FLG_RD = `OEF_CMD_FLAGS_RD;
	localparam oef_cmd_t    FLG_WR = `OEF_CMD_FLAGS_WR;
	localparam oef_cmd_t    MSK_RD = `OEF_CMD_MASK_RD;
	localparam oef_cmd_t    MSK_WR = `OEF_CMD_MASK_WR;

	logic       clk;
	logic       srst;
	oef_cmd_t   regAddr;
	oef_word_t  regWdata;
	logic       regWr;
	logic       regRd;
	oef_word_t  regRdata;
	logic [2:0] pinLevel;
	logic [2:0] line;
	logic [3:0] evtPulse;
	logic [1:0] srpPulse;
	logic       otgIrq;
	int         nMismatch;
	int         checked;

	// Pins: level 0 session end, 1 bus voltage, 2 plug ID; line 2 SE0, 1 J, 0 K.
	oef_event_flags #(
		.SE0_CYCLES  (SE0_N),
		.IDLE_CYCLES (IDLE_N)
	) oef_event_flags_i (
		.clk                      (clk),
		.srst                     (srst),
		.regAddr                  (regAddr),
		.regWdata                 (regWdata),
		.regWr                    (regWr),
		.regRd                    (regRd),
		.regRdata                 (regRdata),
		.sessionEndLevel          (pinLevel[0]),
		.busVoltageValidLevel     (pinLevel[1]),
		.plugIdLevel              (pinLevel[2]),
		.lineSe0                  (line[2]),
		.lineJ                    (line[1]),
		.lineK                    (line[0]),
		.timerExpiredPulse        (evtPulse[0]),
		.remoteConnChangePulse    (evtPulse[1]),
		.bSessionValidChangePulse (evtPulse[2]),
		.aSessionValidChangePulse (evtPulse[3]),
		.vbusPulsingSeen          (srpPulse[0]),
		.dataLinePulsingSeen      (srpPulse[1]),
		.otgIrq                   (otgIrq)
	);

	// ------------------------------------------------------------------------
	// Clock, counters and helpers
	// ------------------------------------------------------------------------
	// The clock toggles every half period of 10 ns.
	always #5 clk = ~clk;

	// Compares one register word and counts the outcome.
	task automatic chkWord(input string what, input oef_word_t exp, input oef_word_t got);
		checked++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Compares the interrupt line and counts the outcome.
	task automatic chkIrq(input logic exp);
		checked++;
		if (otgIrq !== exp)
		begin
			nMismatch++;
			$display("mismatch otgIrq expected %b seen %b", exp, otgIrq);
		end
	endtask

	// One write cycle on the command port.
	task automatic writeReg(input oef_cmd_t code, input oef_word_t data);
		@(posedge clk);
		regWr    <= 1'b1;
		regAddr  <= code;
		regWdata <= data;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// One read cycle; data must stand one cycle only, then fall to zero; ends on an edge.
	task automatic readChk(input oef_cmd_t code, input oef_word_t exp, input string what);
		@(posedge clk);
		regRd   <= 1'b1;
		regAddr <= code;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chkWord(what, exp, regRdata);
		@(posedge clk);
		#1;
		chkWord("read idle", `OEF_WORD_ZERO, regRdata);
		@(posedge clk);
	endtask

	// Checks that only the own enable bit passes a set flag and that only a one clears it.
	task automatic gateAndClear(input oef_word_t one);
		writeReg(MSK_WR, 16'h07FF ^ one);
		repeat (2) @(posedge clk);
		#1 chkIrq(1'b0);
		writeReg(MSK_WR, one);
		repeat (2) @(posedge clk);
		#1 chkIrq(1'b1);
		writeReg(FLG_WR, 16'h07FF ^ one);
		readChk(FLG_RD, one, "flag kept");
		writeReg(FLG_WR, one);
		readChk(FLG_RD, `OEF_WORD_ZERO, "flag cleared");
		#1 chkIrq(1'b0);
		writeReg(MSK_WR, `OEF_WORD_ZERO);
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, nMismatch);
		if (nMismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	// Reset values, mask access, reserved bits and foreign codes.
	task automatic testRegs();
		chkIrq(1'b0);
		readChk(MSK_RD, `OEF_WORD_ZERO, "mask reset");
		readChk(FLG_RD, `OEF_WORD_ZERO, "flags reset");
		writeReg(MSK_WR, 16'hFFFF);
		readChk(MSK_RD, 16'h07FF, "mask all");
		writeReg(MSK_RD, 16'h0000);
		readChk(MSK_RD, 16'h07FF, "read code write");
		writeReg(MSK_WR, 16'h0555);
		readChk(MSK_RD, 16'h0555, "mask pattern");
		readChk(8'h42, `OEF_WORD_ZERO, "unknown code");
		writeReg(MSK_WR, `OEF_WORD_ZERO);
		$display("test regs done");
	endtask

	// Pulse events from the neighbour units, each through its own enable bit.
	task automatic testPulses();
		int        bitPos [4] = '{10, 5, 4, 3};
		oef_word_t one;
		for (int i = 0; i < 4; i++)
		begin
			one = 16'h0001 << bitPos[i];
			@(posedge clk);
			evtPulse <= 4'h1 << i;
			@(posedge clk);
			evtPulse <= 4'h0;
			readChk(FLG_RD, one, "pulse flag");
			gateAndClear(one);
		end
		$display("test pulses done");
	endtask

	// Status level changes in both directions set their change flags.
	task automatic testPins();
		oef_word_t one;
		for (int j = 0; j < 3; j++)
		begin
			one = 16'h0004 >> j;
			@(posedge clk);
			pinLevel <= pinLevel ^ (3'h1 << j);
			repeat (6) @(posedge clk);
			readChk(FLG_RD, one, "pin rise");
			gateAndClear(one);
			pinLevel <= pinLevel ^ (3'h1 << j);
			repeat (6) @(posedge clk);
			readChk(FLG_RD, one, "pin fall");
			writeReg(FLG_WR, one);
		end
		$display("test pins done");
	endtask

	// Session request follows the selected pulsing kind only.
	task automatic testSrp();
		for (int s = 0; s < 2; s++)
		begin
			writeReg(`OEF_CMD_CTRL_WR, 16'(s));
			readChk(`OEF_CMD_CTRL_RD, 16'(s), "srp select");
			@(posedge clk);
			srpPulse <= 2'h2 >> s;
			@(posedge clk);
			srpPulse <= 2'h0;
			readChk(FLG_RD, `OEF_WORD_ZERO, "srp other");
			srpPulse <= 2'h1 << s;
			@(posedge clk);
			srpPulse <= 2'h0;
			readChk(FLG_RD, 16'h0100, "srp chosen");
			gateAndClear(16'h0100);
		end
		$display("test srp done");
	endtask

	// Long SE0, suspend after idle, and resume only from the suspended bus.
	task automatic testLine();
		line <= 3'b010;
		repeat (4) @(posedge clk);
		line <= 3'b001;
		repeat (6) @(posedge clk);
		readChk(FLG_RD, `OEF_WORD_ZERO, "resume active");
		line <= 3'b100;
		repeat (SE0_N) @(posedge clk);
		readChk(FLG_RD, `OEF_WORD_ZERO, "se0 early");
		repeat (10) @(posedge clk);
		readChk(FLG_RD, 16'h0200, "se0 flag");
		line <= 3'b001;
		gateAndClear(16'h0200);
		line <= 3'b010;
		repeat (IDLE_N) @(posedge clk);
		readChk(FLG_RD, `OEF_WORD_ZERO, "idle early");
		repeat (10) @(posedge clk);
		readChk(FLG_RD, 16'h0040, "suspend flag");
		gateAndClear(16'h0040);
		line <= 3'b001;
		repeat (6) @(posedge clk);
		readChk(FLG_RD, 16'h0080, "resume flag");
		gateAndClear(16'h0080);
		$display("test line done");
	endtask

	// A reset in mid-run clears the enable mask, the flags and the interrupt.
	task automatic testReset();
		writeReg(MSK_WR, 16'h07FF);
		@(posedge clk);
		evtPulse <= 4'h1;
		@(posedge clk);
		evtPulse <= 4'h0;
		repeat (2) @(posedge clk);
		#1 chkIrq(1'b1);
		@(posedge clk);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		#1 chkIrq(1'b0);
		readChk(MSK_RD, `OEF_WORD_ZERO, "mask after reset");
		readChk(FLG_RD, `OEF_WORD_ZERO, "flags after reset");
		$display("test reset done");
	endtask

	// ------------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------------
	// Resets the block for four cycles and runs every scenario.
	initial
	begin
		clk       = 1'b0;
		srst      = 1'b1;
		regAddr   = 8'h00;
		regWdata  = 16'h0000;
		regWr     = 1'b0;
		regRd     = 1'b0;
		pinLevel  = 3'b000;
		line      = 3'b001;
		evtPulse  = 4'h0;
		srpPulse  = 2'h0;
		nMismatch = 0;
		checked   = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		testRegs();
		testPulses();
		testPins();
		testSrp();
		testLine();
		testReset();
		finish_test();
	end

	// Cuts a hang short well beyond the expected run of about 560 cycles.
	initial
	begin
		repeat (20000) @(posedge clk);
		nMismatch++;
		finish_test();
	end

endmodule // tb_oef_event_flags
